/* logic/apd_cfg.svh */
// Timing and geometry constants for the page-mode DRAM controller.
// Assumes a 10 MHz system clock (100 ns period).
`ifndef APD_CFG_SVH
`define APD_CFG_SVH
// ----------------------------------------
// Clock and geometry
// ----------------------------------------
`define APD_CLK_NS 100
`define APD_ADDR_W 10
`define APD_DATA_W 16
`define APD_ROWS 1024
// ----------------------------------------
// Timing figures in their own units
// ----------------------------------------
`define APD_PWRUP_US 200
`define APD_REF_WIN_MS 16
`define APD_RAS_MIN_NS 60
`define APD_RP_MIN_NS 40
`define APD_PC_MIN_NS 25
`define APD_INIT_CYCLES 8
// ----------------------------------------
// Derived cycle counts
// ----------------------------------------
`define APD_PWRUP_CYC ((`APD_PWRUP_US * 1000 + `APD_CLK_NS - 1) / `APD_CLK_NS)
`define APD_REF_INT_CYC ((`APD_REF_WIN_MS * 1000000 / `APD_ROWS) / `APD_CLK_NS)
`define APD_RAS_CYC ((`APD_RAS_MIN_NS + `APD_CLK_NS - 1) / `APD_CLK_NS)
`define APD_RP_CYC ((`APD_RP_MIN_NS + `APD_CLK_NS - 1) / `APD_CLK_NS)
`define APD_PC_CYC ((`APD_PC_MIN_NS + `APD_CLK_NS - 1) / `APD_CLK_NS)
`endif

/* logic/apd_pkg.sv */
// Types shared by the page-mode DRAM controller.
// Assumes apd_cfg.svh supplies the numbers.
package apd_pkg;
  typedef enum logic [3:0] {
    APD_ST_PWRUP, APD_ST_IDLE, APD_ST_ROW, APD_ST_COL, APD_ST_COLHI,
    APD_ST_PRE, APD_ST_REF_CAS, APD_ST_REF_RAS, APD_ST_SELF
  } apd_state_e;
endpackage

/* logic/apd_timer.sv */
// Down counter used for power-up pause and refresh interval.
// Assumes a single synchronous clock domain.
`timescale 1ns/1ns
`default_nettype none
module apd_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [15:0] value_i,
  output logic done_o
);
  logic [15:0] cnt_reg;
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Reload wins over counting so an interval never drifts
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 16'h0000;
    end else if (load_i) begin
      cnt_reg <= value_i;
    end else if (cnt_reg != 16'h0000) begin
      cnt_reg <= cnt_reg - 16'h0001;
    end
  end
  assign done_o = (cnt_reg == 16'h0000);
endmodule
`default_nettype wire

/* logic/apd_ctrl.sv */
// Host-side controller for an asynchronous page-mode DRAM (1M x 16).
// Assumes a user port of single requests and the DRAM on its strobe pins.
// Functional notes
// - Row then column on shared address.
// - Respect row active and precharge minimums.
// - Write data valid before first strobe.
// - 1024 refreshes within every 16 ms.
// - Self refresh holds row strobe low.
// - Exit self refresh with row high time.
// - After self refresh, distributed refresh continues.
// - Space page column cycles by minimum.
// - Wait 200 us then eight wake-up cycles.
// - Repeat wake-up after refresh overrun.
`include "apd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module apd_ctrl
  import apd_pkg::*;
#(
  parameter int PWRUP_CYC = `APD_PWRUP_CYC,
  parameter int REF_INT_CYC = `APD_REF_INT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [1:0] req_be_i,
  input wire logic [19:0] req_addr_i,
  input wire logic [15:0] req_wdata_i,
  input wire logic req_last_i,
  input wire logic self_req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  output logic init_done_o,
  output logic self_active_o,
  output logic ras_n_o,
  output logic col_strobe_lo_n_o,
  output logic col_strobe_hi_n_o,
  output logic we_n_o,
  output logic oe_n_o,
  output logic [9:0] addr_o,
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe_o,
  input wire logic [15:0] dq_i
);
  apd_state_e state_reg;
  logic [3:0] wait_reg;
  logic [3:0] init_cnt_reg;
  logic [9:0] open_row_reg;
  logic row_open_reg;
  logic ref_due_reg;
  logic ref_late_reg;
  logic wr_reg;
  logic [1:0] be_reg;
  logic timer_load;
  logic [15:0] timer_value;
  logic timer_done;
  logic page_hit;
  logic ref_req;

  // ----------------------------------------
  // Power-up pause and refresh interval timer
  // ----------------------------------------
  // One timer serves both: power-up first, then the refresh tick
  assign timer_load = timer_done;
  assign timer_value = 16'(REF_INT_CYC - 1);
  apd_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(timer_load | (state_reg == APD_ST_PWRUP && wait_reg == 4'h0 && init_cnt_reg == 4'hf)),
    .value_i((state_reg == APD_ST_PWRUP && init_cnt_reg == 4'hf) ? 16'(PWRUP_CYC - 1) : timer_value),
    .done_o(timer_done)
  );

  assign page_hit = row_open_reg && (req_addr_i[19:10] == open_row_reg);
  assign ref_req = ref_due_reg | ~init_done_o;

  // ----------------------------------------
  // Refresh bookkeeping
  // ----------------------------------------
  // A tick while one is pending, outside self refresh, means the window was overrun
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_due_reg <= 1'b0;
      ref_late_reg <= 1'b0;
    end else begin
      // The flag is spent once idle has seen it; a later set still wins
      if (state_reg == APD_ST_IDLE && wait_reg == 4'h0) begin
        ref_late_reg <= 1'b0;
      end
      if (init_done_o && timer_done && state_reg != APD_ST_PWRUP) begin
        ref_due_reg <= 1'b1;
        if (ref_due_reg && state_reg != APD_ST_SELF) begin
          ref_late_reg <= 1'b1;
        end
      end else if (state_reg == APD_ST_REF_RAS && wait_reg == 4'h0) begin
        ref_due_reg <= 1'b0;
      end
      if (state_reg == APD_ST_PWRUP) begin
        ref_late_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Main sequencer
  // ----------------------------------------
  // Refresh is only taken with the row closed, so no hidden refresh
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= APD_ST_PWRUP;
      wait_reg <= 4'h0;
      init_cnt_reg <= 4'hf;
      init_done_o <= 1'b0;
      open_row_reg <= 10'h000;
      row_open_reg <= 1'b0;
      wr_reg <= 1'b0;
      be_reg <= 2'b00;
      ras_n_o <= 1'b1;
      col_strobe_lo_n_o <= 1'b1;
      col_strobe_hi_n_o <= 1'b1;
      we_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      addr_o <= 10'h000;
      dq_o <= 16'h0000;
      dq_oe_o <= 16'h0000;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0000;
      self_active_o <= 1'b0;
    end else begin
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      if (wait_reg != 4'h0) begin
        wait_reg <= wait_reg - 4'h1;
      end
      unique case (state_reg)
        APD_ST_PWRUP: begin
          // First cycle loads the pause; then wait for it to drain
          if (init_cnt_reg == 4'hf) begin
            init_cnt_reg <= 4'(`APD_INIT_CYCLES);
          end else if (timer_done) begin
            state_reg <= APD_ST_IDLE;
          end
        end
        APD_ST_IDLE: begin
          if (wait_reg == 4'h0) begin
            if (ref_late_reg) begin
              init_done_o <= 1'b0;
              init_cnt_reg <= 4'(`APD_INIT_CYCLES);
            end
            if (ref_req || ref_late_reg) begin
              col_strobe_lo_n_o <= 1'b0;
              col_strobe_hi_n_o <= 1'b0;
              dq_oe_o <= 16'h0000;
              state_reg <= APD_ST_REF_CAS;
            end else if (self_req_i) begin
              col_strobe_lo_n_o <= 1'b0;
              col_strobe_hi_n_o <= 1'b0;
              self_active_o <= 1'b1;
              state_reg <= APD_ST_REF_CAS;
            end else if (req_valid_i) begin
              addr_o <= req_addr_i[19:10];
              open_row_reg <= req_addr_i[19:10];
              ras_n_o <= 1'b0;
              wait_reg <= 4'(`APD_RAS_CYC);
              state_reg <= APD_ST_ROW;
            end
          end
        end
        APD_ST_ROW: begin
          // Column address goes out the cycle before its strobe falls
          row_open_reg <= 1'b1;
          addr_o <= req_addr_i[9:0];
          wr_reg <= req_write_i;
          be_reg <= req_be_i;
          we_n_o <= ~req_write_i;
          dq_o <= req_wdata_i;
          dq_oe_o <= req_write_i ? {{8{req_be_i[1]}}, {8{req_be_i[0]}}} : 16'h0000;
          oe_n_o <= req_write_i;
          state_reg <= APD_ST_COL;
        end
        APD_ST_COL: begin
          col_strobe_lo_n_o <= ~be_reg[0];
          col_strobe_hi_n_o <= ~be_reg[1];
          req_ready_o <= 1'b1;
          state_reg <= APD_ST_COLHI;
        end
        APD_ST_COLHI: begin
          // Sample read data one full cycle after the strobe fell
          if (!wr_reg && req_ready_o) begin // First column-high cycle only
            rsp_rdata_o <= dq_i;
            rsp_valid_o <= 1'b1;
          end
          col_strobe_lo_n_o <= 1'b1;
          col_strobe_hi_n_o <= 1'b1;
          we_n_o <= 1'b1;
          dq_oe_o <= 16'h0000;
          if (req_valid_i && !req_last_i && page_hit && !ref_req && !req_ready_o) begin
            state_reg <= APD_ST_ROW;
          end else if (wait_reg == 4'h0 && !req_ready_o) begin
            state_reg <= APD_ST_PRE;
          end
        end
        APD_ST_PRE: begin
          ras_n_o <= 1'b1;
          oe_n_o <= 1'b1;
          row_open_reg <= 1'b0;
          wait_reg <= 4'(`APD_RP_CYC);
          state_reg <= APD_ST_IDLE;
        end
        APD_ST_REF_CAS: begin
          ras_n_o <= 1'b0;
          wait_reg <= 4'(`APD_RAS_CYC);
          state_reg <= self_active_o ? APD_ST_SELF : APD_ST_REF_RAS;
        end
        APD_ST_REF_RAS: begin
          if (wait_reg == 4'h0) begin
            ras_n_o <= 1'b1;
            col_strobe_lo_n_o <= 1'b1;
            col_strobe_hi_n_o <= 1'b1;
            wait_reg <= 4'(`APD_RP_CYC);
            if (!init_done_o) begin
              if (init_cnt_reg == 4'h1) begin
                init_done_o <= 1'b1;
              end
              init_cnt_reg <= init_cnt_reg - 4'h1;
            end
            state_reg <= APD_ST_IDLE;
          end
        end
        APD_ST_SELF: begin
          // Leaving: row high for the precharge time lets internal work end
          if (!self_req_i && wait_reg == 4'h0) begin
            ras_n_o <= 1'b1;
            col_strobe_lo_n_o <= 1'b1;
            col_strobe_hi_n_o <= 1'b1;
            self_active_o <= 1'b0;
            wait_reg <= 4'(`APD_RP_CYC);
            state_reg <= APD_ST_IDLE;
          end
        end
        default: begin
          state_reg <= APD_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* bench/apd_ctrl_sva.sv */
// Pin checker for the page-mode DRAM controller.
// Assumes it is bound onto apd_ctrl and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module apd_ctrl_sva #(
  parameter int PWRUP_CYC = 20,
  parameter int REF_INT_CYC = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [19:0] req_addr_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic init_done_o,
  input wire logic self_active_o,
  input wire logic ras_n_o,
  input wire logic col_strobe_lo_n_o,
  input wire logic col_strobe_hi_n_o,
  input wire logic we_n_o,
  input wire logic oe_n_o,
  input wire logic [9:0] addr_o,
  input wire logic [15:0] dq_oe_o
);
  wire logic cas_lo = !(col_strobe_lo_n_o && col_strobe_hi_n_o);
  wire logic [15:0] lanes = {{8{!col_strobe_hi_n_o}}, {8{!col_strobe_lo_n_o}}};
  int up_cnt, gap_cnt, wake_cnt;
  // Gap restarts on each refresh; self refresh keeps its own rows alive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      up_cnt <= 0;
      gap_cnt <= 0;
      wake_cnt <= 0;
    end else begin
      if (up_cnt < PWRUP_CYC) up_cnt <= up_cnt + 1;
      gap_cnt <= (self_active_o || (cas_lo && $fell(ras_n_o))) ? 0 : gap_cnt + 1;
      if (!init_done_o && $fell(ras_n_o)) wake_cnt <= wake_cnt + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_row_addr: assert property ($fell(ras_n_o) && !cas_lo |-> addr_o == req_addr_i[19:10])
    else $error("row address wrong");
  a_col_addr: assert property ($rose(cas_lo) && !ras_n_o |-> addr_o == req_addr_i[9:0])
    else $error("column address wrong");
  a_cycle_end: assert property ($rose(ras_n_o) |-> ##[0:2] !cas_lo)
    else $error("column strobe left low");
  a_early_write: assert property ($rose(cas_lo) && !we_n_o && !ras_n_o |-> !$past(we_n_o) && (dq_oe_o & lanes) == lanes)
    else $error("write data late");
  a_read_quiet: assert property ($rose(cas_lo) && we_n_o && !ras_n_o |-> !oe_n_o && dq_oe_o == 16'h0)
    else $error("read badly set up");
  a_pwrup_quiet: assert property (up_cnt < PWRUP_CYC - 1 |-> ras_n_o)
    else $error("row strobe in power-up pause");
  a_wake_count: assert property ($rose(init_done_o) |-> wake_cnt >= 8)
    else $error("too few wake-up cycles");
  a_ref_gap: assert property (init_done_o |-> gap_cnt <= 2 * REF_INT_CYC)
    else $error("refresh overdue");
  a_rsp_single: assert property (rsp_valid_o |=> !rsp_valid_o)
    else $error("read response longer than one cycle");
  a_rsp_after_take: assert property (rsp_valid_o |-> $past(req_ready_o))
    else $error("read response without a taken request");
  c_self: cover property ($rose(self_active_o));
  c_write: cover property ($rose(cas_lo) && !we_n_o && !ras_n_o);
  c_read: cover property ($rose(cas_lo) && we_n_o && !ras_n_o);
endmodule
bind apd_ctrl apd_ctrl_sva #(.PWRUP_CYC(PWRUP_CYC), .REF_INT_CYC(REF_INT_CYC)) chk_u (.clk_i, .rst_i,
  .req_addr_i, .req_ready_o, .rsp_valid_o, .init_done_o, .self_active_o, .ras_n_o, .col_strobe_lo_n_o,
  .col_strobe_hi_n_o,
  .we_n_o, .oe_n_o, .addr_o, .dq_oe_o);
`default_nettype wire

/* bench/apd_dram_model.sv */
// Behavioural page-mode DRAM seen on its strobe pins.
// Assumes the controller's driven bits are merged into dq_o here.
`timescale 1ns/1ns
`default_nettype none
module apd_dram_model (
  input wire logic ras_n_i,
  input wire logic lo_n_i,
  input wire logic hi_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [9:0] addr_i,
  input wire logic [15:0] cd_i,
  input wire logic [15:0] ce_i,
  output logic [15:0] dq_o
);
  logic [15:0] mem [bit [19:0]];
  logic [15:0] rd = 16'h5a5a;
  logic [15:0] dev;
  logic [9:0] row;
  logic [9:0] refc = 10'h0;
  logic [1:0] drv = 2'h0;
  logic refr = 0;
  wire logic cas_n = lo_n_i & hi_n_i;
  // Short settle so pins launched on one clock edge are all seen
  always @(negedge ras_n_i) begin
    #1;
    refr = !cas_n;
    if (refr) refc = refc + 10'h1;
    else row = addr_i;
  end
  always @(negedge cas_n) begin
    #1;
    if (!ras_n_i && !refr && !we_n_i) begin
      drv = 2'h0;
      if (!lo_n_i) mem[{row, addr_i}][7:0] = cd_i[7:0];
      if (!hi_n_i) mem[{row, addr_i}][15:8] = cd_i[15:8];
    end else if (!ras_n_i && !refr) begin
      rd = mem[{row, addr_i}];
      drv = ~{hi_n_i, lo_n_i};
    end
  end
  // Data outlives the strobe rise; dropped when the cycle ends or a write strobe falls
  always @(posedge ras_n_i or posedge cas_n) if (ras_n_i && cas_n) drv = 2'h0;
  assign dev = {{8{drv[1]}}, {8{drv[0]}}} & {16{!oe_n_i}};
  // Released lines show the inverse, so stale data never passes
  assign dq_o = (ce_i & cd_i) | (~ce_i & dev & rd) | (~ce_i & ~dev & ~rd);
endmodule
`default_nettype wire

/* bench/test_async_page_dram_port.sv */
// Self-checking bench for the page-mode DRAM controller.
// Assumes the pin checker is bound and the DRAM model sits on the pins.
`timescale 1ns/1ns
`default_nettype none
module test_async_page_dram_port;
  logic clk_i = 0, rst_i = 1, req_valid_i = 0, req_write_i = 0, req_last_i = 0, self_req_i = 0;
  logic [1:0] req_be_i = 2'h3;
  logic [19:0] req_addr_i = 20'h0;
  logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, dq_o, dq_oe_o, dq_i;
  logic req_ready_o, rsp_valid_o, init_done_o, self_active_o, ras_n_o;
  logic col_strobe_lo_n_o, col_strobe_hi_n_o, we_n_o, oe_n_o;
  logic [9:0] addr_o;
  logic [15:0] ref_mem [bit [19:0]];
  int error_cnt = 0, check_count = 0, refs = 0;
  apd_ctrl #(.PWRUP_CYC(20), .REF_INT_CYC(40)) dut_u (.clk_i, .rst_i, .req_valid_i, .req_write_i,
    .req_be_i, .req_addr_i, .req_wdata_i, .req_last_i, .self_req_i, .req_ready_o, .rsp_valid_o,
    .rsp_rdata_o, .init_done_o, .self_active_o, .ras_n_o, .col_strobe_lo_n_o, .col_strobe_hi_n_o,
    .we_n_o, .oe_n_o, .addr_o, .dq_o, .dq_oe_o, .dq_i);
  apd_dram_model mem_u (.ras_n_i(ras_n_o), .lo_n_i(col_strobe_lo_n_o), .hi_n_i(col_strobe_hi_n_o),
    .we_n_i(we_n_o), .oe_n_i(oe_n_o), .addr_i(addr_o), .cd_i(dq_o), .ce_i(dq_oe_o), .dq_o(dq_i));
  initial forever #50 clk_i = ~clk_i;
  // Strobe-first refreshes counted on the pins
  always @(negedge ras_n_o) if (!(col_strobe_lo_n_o && col_strobe_hi_n_o)) refs++;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Request held past the edge that takes it; reads judged on asked lanes only
  task automatic xfer(input logic w, input logic [1:0] be, input logic [19:0] a, input logic [15:0] d,
    input logic l);
    logic [15:0] m;
    int n;
    m = {{8{be[1]}}, {8{be[0]}}};
    n = 0;
    {req_valid_i, req_write_i, req_be_i, req_addr_i, req_wdata_i, req_last_i} = {1'b1, w, be, a, d, l};
    do begin
      @(negedge clk_i);
      n++;
    end while (!req_ready_o && n < 99);
    check({15'h0, req_ready_o}, 16'h1);
    @(negedge clk_i);
    if (w) ref_mem[a] = (ref_mem[a] & ~m) | (d & m);
    else check(rsp_rdata_o & m, ref_mem[a] & m);
    if (!w) check({15'h0, rsp_valid_o}, 16'h1);
  endtask
  task automatic idle();
    req_valid_i = 0;
    @(negedge clk_i);
  endtask
  task automatic t_init();
    for (int n = 0; n < 400 && !init_done_o; n++) @(negedge clk_i);
    check({15'h0, init_done_o}, 16'h1);
    check({15'h0, refs >= 8}, 16'h1);
    $display("init ok");
  endtask
  task automatic t_basic();
    xfer(1, 2'h3, 20'h003ff, 16'h1234, 1);
    xfer(1, 2'h1, 20'hffc00, 16'h00ab, 1);
    xfer(1, 2'h2, 20'hffc00, 16'hcd00, 1);
    xfer(0, 2'h3, 20'hffc00, 16'h0, 1);
    xfer(0, 2'h2, 20'h003ff, 16'h0, 1);
    xfer(0, 2'h1, 20'h003ff, 16'h0, 1);
    idle();
    $display("basic ok");
  endtask
  task automatic t_page();
    for (int i = 0; i < 4; i++) xfer(1, 2'h3, {10'h155, 10'h3fc + 10'(i)}, 16'ha000 + 16'(i), 0);
    for (int i = 3; i >= 0; i--) xfer(0, 2'h3, {10'h155, 10'h3fc + 10'(i)}, 16'h0, i == 0);
    idle();
    $display("page ok");
  endtask
  task automatic t_refresh();
    int r0;
    r0 = refs;
    repeat (200) @(negedge clk_i);
    check({15'h0, refs - r0 >= 4}, 16'h1);
    xfer(0, 2'h3, 20'h003ff, 16'h0, 1);
    idle();
    $display("refresh ok");
  endtask
  // A read waits through self refresh and must complete after exit
  task automatic t_self();
    logic bad;
    bad = 0;
    self_req_i = 1;
    for (int n = 0; n < 99 && !self_active_o; n++) @(negedge clk_i);
    {req_valid_i, req_write_i, req_be_i, req_addr_i, req_last_i} = {1'b1, 1'b0, 2'h3, 20'hffc00, 1'b1};
    repeat (30) begin
      @(negedge clk_i);
      bad |= req_ready_o | ras_n_o | !self_active_o;
    end
    check({15'h0, bad}, 16'h0);
    self_req_i = 0;
    xfer(0, 2'h3, 20'hffc00, 16'h0, 1);
    idle();
    $display("self refresh ok");
  endtask
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 0;
    t_init();
    t_basic();
    t_page();
    t_refresh();
    t_self();
    wrap_up();
  end
  // The run needs under two thousand cycles; this cuts a hang short
  initial begin
    #(5000 * 100);
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
